// *** hdl/sscp_map.vh ***
// Field positions, reset values and timing figures of the stepper serial configuration port
`ifndef SSCP_MAP_VH
`define SSCP_MAP_VH

// Serial word framing
`define SSCP_WORD_BITS      16
`define SSCP_BITCNT_W       5
`define SSCP_BITCNT_FULL    5'h10
`define SSCP_BITCNT_MAX     5'h1f
`define SSCP_SEL_BIT        15
`define SSCP_KEEP_BIT       14

// System configuration word fields
`define SSCP_CFG_TSC_BIT    12
`define SSCP_CFG_OL_BIT     11
`define SSCP_CFG_CD_HI      10
`define SSCP_CFG_CD_LO      6
`define SSCP_CFG_MS_HI      5
`define SSCP_CFG_MS_LO      4
`define SSCP_CFG_HLR_BIT    3
`define SSCP_CFG_TBK_BIT    2
`define SSCP_CFG_FRQ_HI     1
`define SSCP_CFG_FRQ_LO     0
`define SSCP_CFG_RESET      16'h0001

// Motor run control word fields
`define SSCP_RUN_DG_HI      12
`define SSCP_RUN_DG_LO      10
`define SSCP_RUN_SR_BIT     9
`define SSCP_RUN_DIS_BIT    8
`define SSCP_RUN_SC_HI      5
`define SSCP_RUN_SC_LO      0
`define SSCP_RUN_RESET      16'h8000

// Fault routing codes
`define SSCP_DG_ALL         3'h0
`define SSCP_DG_SUPPLY      3'h1
`define SSCP_DG_OPEN        3'h2
`define SSCP_DG_TEMP        3'h3

// Step size codes
`define SSCP_STEP_FULL      2'h0
`define SSCP_STEP_HALF      2'h1
`define SSCP_STEP_QUARTER   2'h2
`define SSCP_STEP_EIGHTH    2'h3

// Entry sequence phase codes
`define SSCP_SEQ_P0         2'h0
`define SSCP_SEQ_P1         2'h1
`define SSCP_SEQ_P2         2'h2
`define SSCP_SEQ_P3         2'h3

// Internal 4 MHz clock figures, times in ns
`define SSCP_INT_CLK_KHZ    4000
`define SSCP_OC_SHORT_NS    2000
`define SSCP_OC_LONG_NS     4000
`define SSCP_BLANK_LONG_NS  3500
`define SSCP_BLANK_SHORT_NS 1500
`define SSCP_PWM_00_NS      60000
`define SSCP_PWM_01_NS      46000
`define SSCP_PWM_10_NS      40000
`define SSCP_PWM_11_NS      32000
`define SSCP_OL_LOW_PCT     6'h14
`define SSCP_OL_HIGH_PCT    6'h1e

// Default serial mode timing, ns
`define SSCP_SEQ_HOLD_NS    5000
`define SSCP_ACK_PULSE_NS   10000
`define SSCP_EXIT_NS        2000
`define SSCP_CLK_PERIOD_NS  20

`endif

// *** hdl/sscp_sync.v ***
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module sscp_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // Clock, reset, enable
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             ce_in,
  // Pins and their synchronised copy
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // The first stage feeds only the second stage
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
    end
    else if (ce_in)
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // sscp_sync

// *** hdl/sscp_top.v ***
// Serial configuration port of a stepper driver: mode entry, 16-bit receiver, registers
// What this block does
// - Powers up in step/direction mode; serial port idle until entry accepted.
// - Step low at any time abandons the entry sequence back to its first phase.
// - Accepted entry inverts the fault pin for the acknowledge time.
// - In serial mode step, direction, resolution pins become strobe, data, clock.
// - Keep bit 0 in a transfer returns to step mode after the exit time.
// - Leaving serial mode restores pin functions and inverts the fault pin.
// - Acknowledge is an inversion of the live routed fault signal.
// - Data shifts on serial clock rising edges only while strobe is low.
// - After 16 bits the strobe rise latches the word and acts on it.
// - Any bit count other than 16 discards the word and sets write fault.
// - Write fault clears on valid transfer, power-on reset, or chip reset pulse.
// - Word is MSB first; bit 15 selects configuration or run register.
// - Configuration fields: keep, delay, open load, stall, table, recirc, blank, PWM.
// - Configuration resets to zero except PWM period select at binary 01.
// - Delay select gives 2 or 4 us overcurrent confirmation in 4 MHz ticks.
// - Open load level selects 20 or 30 percent of maximum current.
// - Stall threshold sets count difference; zero disables stall detection.
// - Table select maps resolution pin level to a step size.
// - Recirculation select chooses high side or low side slow decay path.
// - Blanking select gives 3.5 or 1.5 us in 4 MHz ticks.
// - PWM period select gives 60, 46, 40 or 32 us.
// - Fault route select picks all, supply, open load, temperature or stall.
// - Step increment is two's complement, moving the step angle number.
// - Bridge off set disables both bridges; reset leaves them enabled.
`timescale 1ns/100ps
`include "sscp_map.vh"
module sscp_top #(
  parameter CLK_PERIOD_NS = `SSCP_CLK_PERIOD_NS,
  parameter SEQ_HOLD_NS   = `SSCP_SEQ_HOLD_NS,
  parameter ACK_PULSE_NS  = `SSCP_ACK_PULSE_NS,
  parameter EXIT_NS       = `SSCP_EXIT_NS,
  parameter CNT_W         = 16
) (
  // Clock, reset, enable
  input  wire       clk_sys_in,
  input  wire       rst_n_in,
  input  wire       ce_in,
  // Motion control pins, shared with the serial port
  input  wire       motion_pulse_in,
  input  wire       rotation_sense_in,
  input  wire       resolution_select_in,
  input  wire       chip_reset_n_in,
  // Fault sources from the diagnostics, active high
  input  wire       fault_supply_in,
  input  wire       fault_open_load_in,
  input  wire       fault_temp_in,
  input  wire       fault_stall_in,
  input  wire       fault_short_in,
  // Fault pin, active low
  output reg        fault_indicator_out,
  // Mode and step/direction routing
  output reg        serial_mode_out,
  output reg        step_pulse_out,
  output reg        step_dir_out,
  output reg  [1:0] step_size_out,
  // Configuration derived settings
  output reg  [7:0] oc_delay_ticks_out,
  output reg  [5:0] open_load_pct_out,
  output reg  [4:0] stall_threshold_out,
  output reg        stall_detect_en_out,
  output reg        recirc_low_side_out,
  output reg  [7:0] blank_ticks_out,
  output reg  [7:0] pwm_period_ticks_out,
  // Run settings
  output reg  [2:0] fault_route_select_out,
  output reg        diode_recirc_out,
  output reg        bridge_off_out,
  output reg  [5:0] step_increment_out,
  output reg  [5:0] step_angle_out,
  // Write events and write fault
  output reg        cfg_write_out,
  output reg        run_write_out,
  output reg        serial_write_fault_out
);

  // Cycle counts: least times round up, none below one cycle
  localparam integer SEQ_HOLD_RAW = (SEQ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam integer ACK_RAW      = (ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam integer EXIT_RAW     = (EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam [CNT_W-1:0] CNT_ZERO     = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE      = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] SEQ_HOLD_CYC = (SEQ_HOLD_RAW < 1) ? CNT_ONE : SEQ_HOLD_RAW[CNT_W-1:0];
  localparam [CNT_W-1:0] ACK_CYC      = (ACK_RAW < 1) ? CNT_ONE : ACK_RAW[CNT_W-1:0];
  localparam [CNT_W-1:0] EXIT_CYC     = (EXIT_RAW < 1) ? CNT_ONE : EXIT_RAW[CNT_W-1:0];

  // Nanoseconds to internal 4 MHz clock ticks
  function [7:0] ns_to_ticks;
    input integer ns;
    integer t;
    begin
      t = (ns * `SSCP_INT_CLK_KHZ) / 1000000;
      ns_to_ticks = t[7:0];
    end
  endfunction

  // Step size from table select and resolution pin level
  function [1:0] step_size;
    input [1:0] tbl;
    input       ms;
    begin
      case (tbl)
        2'h0:    step_size = ms ? `SSCP_STEP_QUARTER : `SSCP_STEP_HALF;
        2'h1:    step_size = ms ? `SSCP_STEP_HALF    : `SSCP_STEP_FULL;
        2'h2:    step_size = ms ? `SSCP_STEP_QUARTER : `SSCP_STEP_FULL;
        default: step_size = ms ? `SSCP_STEP_EIGHTH  : `SSCP_STEP_HALF;
      endcase
    end
  endfunction

  // Reset release through two flip-flops
  reg  rst_meta_q;
  reg  rst_sync_q;
  wire rst_n;

  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // Pin synchroniser: step, direction, resolution, chip reset
  wire [3:0] pins_s;
  wire       step_s;
  wire       dir_s;
  wire       ms_s;
  wire       chip_rst_n_s;

  sscp_sync #(
    .WIDTH (4),
    .INIT  (4'h8)
  ) u_sync (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n),
    .ce_in    (ce_in),
    .async_in ({chip_reset_n_in, resolution_select_in, rotation_sense_in, motion_pulse_in}),
    .sync_out (pins_s)
  );

  assign step_s       = pins_s[0];
  assign dir_s        = pins_s[1];
  assign ms_s         = pins_s[2];
  assign chip_rst_n_s = pins_s[3];

  // State
  reg                        serial_q;
  reg  [1:0]                 seq_q;
  reg                        seq_done_q;
  reg  [CNT_W-1:0]           seq_cnt_q;
  reg  [1:0]                 pat_prev_q;
  reg  [CNT_W-1:0]           ack_cnt_q;
  reg  [CNT_W-1:0]           exit_cnt_q;
  reg                        strobe_prev_q;
  reg                        sck_prev_q;
  reg  [`SSCP_WORD_BITS-1:0] shift_q;
  reg  [`SSCP_BITCNT_W-1:0]  bit_cnt_q;
  reg  [`SSCP_WORD_BITS-1:0] cfg_q;
  reg  [`SSCP_WORD_BITS-1:0] run_q;
  reg                        wr_fault_q;
  reg  [5:0]                 angle_q;
  reg                        cfg_wr_q;
  reg                        run_wr_q;

  // Pattern is {resolution, direction}; phases 0 and 2 share a pattern
  wire [1:0] pat          = {ms_s, dir_s};
  wire       pat_changed  = (pat != pat_prev_q);
  wire       pat_a        = (pat == 2'h2);
  wire       pat_b        = (pat == 2'h1);
  wire       cur_match    = (seq_q == `SSCP_SEQ_P1) ? pat_b :
                            (seq_q == `SSCP_SEQ_P3) ? dir_s : pat_a;
  wire       next_match   = (seq_q == `SSCP_SEQ_P0) ? pat_b :
                            (seq_q == `SSCP_SEQ_P1) ? pat_a : dir_s;
  wire       enter_serial = !serial_q && step_s && (seq_q == `SSCP_SEQ_P3) && cur_match &&
                            (seq_cnt_q == SEQ_HOLD_CYC);

  // Serial events; strobe, data and clock are the reused pins
  wire strobe_n  = step_s;
  wire serial_data_in       = dir_s;
  wire sck       = ms_s;
  wire sck_rise  = serial_q && !strobe_n && sck && !sck_prev_q;
  wire strb_rise = serial_q && strobe_n && !strobe_prev_q;
  wire word_ok   = strb_rise && (bit_cnt_q == `SSCP_BITCNT_FULL);
  wire word_bad  = strb_rise && (bit_cnt_q != `SSCP_BITCNT_FULL);
  wire exit_done = (exit_cnt_q == CNT_ONE);

  // Entry sequence: phase counter timed per held pattern, reset by step low
  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_q      <= `SSCP_SEQ_P0;
      seq_done_q <= 1'b0;
      seq_cnt_q  <= CNT_ZERO;
      pat_prev_q <= 2'h0;
    end
    else if (ce_in)
    begin
      pat_prev_q <= pat;
      if (serial_q || !step_s || enter_serial)
      begin
        seq_q      <= `SSCP_SEQ_P0;
        seq_done_q <= 1'b0;
        seq_cnt_q  <= CNT_ZERO;
      end
      else if (pat_changed)
      begin
        seq_cnt_q <= CNT_ZERO;
        if (seq_done_q && next_match)
        begin
          seq_q      <= seq_q + 2'h1;
          seq_done_q <= 1'b0;
        end
      end
      else if (cur_match && seq_cnt_q != SEQ_HOLD_CYC)
        seq_cnt_q <= seq_cnt_q + CNT_ONE;
      else if (cur_match && seq_q != `SSCP_SEQ_P3)
        seq_done_q <= 1'b1;
    end
  end

  // Mode, acknowledge timer and exit timer
  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_q   <= 1'b0;
      ack_cnt_q  <= CNT_ZERO;
      exit_cnt_q <= CNT_ZERO;
    end
    else if (ce_in)
    begin
      if (enter_serial)
      begin
        serial_q  <= 1'b1;
        ack_cnt_q <= ACK_CYC;
      end
      else if (exit_done)
      begin
        serial_q   <= 1'b0;
        exit_cnt_q <= CNT_ZERO;
        ack_cnt_q  <= ACK_CYC;
      end
      else
      begin
        if (ack_cnt_q != CNT_ZERO)
          ack_cnt_q <= ack_cnt_q - CNT_ONE;
        if (word_ok && !shift_q[`SSCP_KEEP_BIT])
          exit_cnt_q <= EXIT_CYC;
        else if (exit_cnt_q != CNT_ZERO)
          exit_cnt_q <= exit_cnt_q - CNT_ONE;
      end
    end
  end

  // Receiver: shift MSB first while strobe low, count edges, judge on strobe rise
  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_prev_q <= 1'b1;
      sck_prev_q    <= 1'b0;
      shift_q       <= {`SSCP_WORD_BITS{1'b0}};
      bit_cnt_q     <= {`SSCP_BITCNT_W{1'b0}};
      wr_fault_q    <= 1'b0;
    end
    else if (ce_in)
    begin
      strobe_prev_q <= strobe_n;
      sck_prev_q    <= sck;
      if (!serial_q || strobe_n)
        bit_cnt_q <= {`SSCP_BITCNT_W{1'b0}};
      else if (sck_rise)
      begin
        shift_q <= {shift_q[`SSCP_WORD_BITS-2:0], serial_data_in};
        if (bit_cnt_q != `SSCP_BITCNT_MAX)
          bit_cnt_q <= bit_cnt_q + 5'h01;                    // Saturates so long words stay invalid
      end
      // A bad word sets the fault even if a clear arrives together
      if (word_bad)
        wr_fault_q <= 1'b1;
      else if (word_ok || !chip_rst_n_s)
        wr_fault_q <= 1'b0;
    end
  end

  // Register latch on a valid word, and step angle update on run writes
  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q    <= `SSCP_CFG_RESET;
      run_q    <= `SSCP_RUN_RESET;
      angle_q  <= 6'h00;
      cfg_wr_q <= 1'b0;
      run_wr_q <= 1'b0;
    end
    else if (ce_in)
    begin
      cfg_wr_q <= word_ok && !shift_q[`SSCP_SEL_BIT];
      run_wr_q <= word_ok && shift_q[`SSCP_SEL_BIT];
      if (word_ok && shift_q[`SSCP_SEL_BIT])
      begin
        run_q   <= shift_q;
        angle_q <= angle_q + shift_q[`SSCP_RUN_SC_HI:`SSCP_RUN_SC_LO];
      end
      else if (word_ok)
        cfg_q <= shift_q;
    end
  end

  // Fault routing; all faults also include the serial write fault
  wire [2:0] dg = run_q[`SSCP_RUN_DG_HI:`SSCP_RUN_DG_LO];
  wire any_fault = fault_supply_in | fault_open_load_in | fault_temp_in |
                   fault_stall_in | fault_short_in | wr_fault_q;
  wire routed = dg[2]                 ? fault_stall_in     :
                (dg == `SSCP_DG_SUPPLY) ? fault_supply_in  :
                (dg == `SSCP_DG_OPEN)   ? fault_open_load_in :
                (dg == `SSCP_DG_TEMP)   ? fault_temp_in    : any_fault;

  // Registered outputs; settings are decoded here so the pins see flip-flops only
  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_indicator_out    <= 1'b1;
      serial_mode_out        <= 1'b0;
      step_pulse_out         <= 1'b0;
      step_dir_out           <= 1'b0;
      step_size_out          <= `SSCP_STEP_HALF;
      oc_delay_ticks_out     <= 8'h00;
      open_load_pct_out      <= 6'h00;
      stall_threshold_out    <= 5'h00;
      stall_detect_en_out    <= 1'b0;
      recirc_low_side_out    <= 1'b0;
      blank_ticks_out        <= 8'h00;
      pwm_period_ticks_out   <= 8'h00;
      fault_route_select_out <= 3'h0;
      diode_recirc_out       <= 1'b0;
      bridge_off_out         <= 1'b0;
      step_increment_out     <= 6'h00;
      step_angle_out         <= 6'h00;
      cfg_write_out          <= 1'b0;
      run_write_out          <= 1'b0;
      serial_write_fault_out <= 1'b0;
    end
    else if (ce_in)
    begin
      // Live fault inverted while acknowledging, so a fault change shows mid-pulse
      fault_indicator_out    <= ~routed ^ (ack_cnt_q != CNT_ZERO);
      serial_mode_out        <= serial_q;
      // Step and direction pins pass through only in step mode; the resolution pin feeds the step size in both modes
      step_pulse_out         <= !serial_q && step_s;
      step_dir_out           <= !serial_q && dir_s;
      step_size_out          <= step_size(cfg_q[`SSCP_CFG_MS_HI:`SSCP_CFG_MS_LO], ms_s);
      oc_delay_ticks_out     <= cfg_q[`SSCP_CFG_TSC_BIT] ? ns_to_ticks(`SSCP_OC_LONG_NS) :
                                                           ns_to_ticks(`SSCP_OC_SHORT_NS);
      open_load_pct_out      <= cfg_q[`SSCP_CFG_OL_BIT] ? `SSCP_OL_HIGH_PCT : `SSCP_OL_LOW_PCT;
      stall_threshold_out    <= cfg_q[`SSCP_CFG_CD_HI:`SSCP_CFG_CD_LO];
      stall_detect_en_out    <= (cfg_q[`SSCP_CFG_CD_HI:`SSCP_CFG_CD_LO] != 5'h00);
      recirc_low_side_out    <= cfg_q[`SSCP_CFG_HLR_BIT];
      blank_ticks_out        <= cfg_q[`SSCP_CFG_TBK_BIT] ? ns_to_ticks(`SSCP_BLANK_SHORT_NS) :
                                                           ns_to_ticks(`SSCP_BLANK_LONG_NS);
      case (cfg_q[`SSCP_CFG_FRQ_HI:`SSCP_CFG_FRQ_LO])
        2'h0:    pwm_period_ticks_out <= ns_to_ticks(`SSCP_PWM_00_NS);
        2'h1:    pwm_period_ticks_out <= ns_to_ticks(`SSCP_PWM_01_NS);
        2'h2:    pwm_period_ticks_out <= ns_to_ticks(`SSCP_PWM_10_NS);
        default: pwm_period_ticks_out <= ns_to_ticks(`SSCP_PWM_11_NS);
      endcase
      fault_route_select_out <= dg;
      diode_recirc_out       <= run_q[`SSCP_RUN_SR_BIT];
      bridge_off_out         <= run_q[`SSCP_RUN_DIS_BIT];
      step_increment_out     <= run_q[`SSCP_RUN_SC_HI:`SSCP_RUN_SC_LO];
      step_angle_out         <= angle_q;
      cfg_write_out          <= cfg_wr_q;
      run_write_out          <= run_wr_q;
      serial_write_fault_out <= wr_fault_q;
    end
  end

endmodule // sscp_top

// *** tb/sscp_top_assertions.sv ***
// Concurrent checks on the ports of the serial configuration port
`timescale 1ns/100ps
module sscp_top_assertions (
  // Clock and reset
  input wire       clk_sys_in,
  input wire       rst_n_in,
  // Inputs watched
  input wire       chip_reset_n_in,
  input wire       fault_supply_in,
  input wire       fault_open_load_in,
  input wire       fault_temp_in,
  input wire       fault_stall_in,
  input wire       fault_short_in,
  // Outputs watched
  input wire       fault_indicator_out,
  input wire       serial_mode_out,
  input wire       step_pulse_out,
  input wire       step_dir_out,
  input wire [4:0] stall_threshold_out,
  input wire       stall_detect_en_out,
  input wire [5:0] step_angle_out,
  input wire       cfg_write_out,
  input wire       run_write_out,
  input wire       serial_write_fault_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // No fault source active, so the pin idles high and an acknowledge shows as low
  wire quiet_w = !(fault_supply_in | fault_open_load_in | fault_temp_in | fault_stall_in | fault_short_in |
                   serial_write_fault_out);
  wire wr_w    = cfg_write_out | run_write_out;
  sequence s_ack_lo;
    !fault_indicator_out [*8];
  endsequence
  property p_ack_entry;
    $rose(serial_mode_out) && quiet_w |-> ##[0:2] s_ack_lo;
  endproperty
  a_ack_entry: assert property (p_ack_entry)
    else $error("no acknowledge after entry");
  property p_ack_exit;
    $fell(serial_mode_out) && quiet_w |-> s_ack_lo;
  endproperty
  a_ack_exit: assert property (p_ack_exit)
    else $error("no acknowledge after exit");
  property p_pins_taken;
    serial_mode_out && $past(serial_mode_out, 2) |-> !step_pulse_out && !step_dir_out;
  endproperty
  a_pins_taken: assert property (p_pins_taken)
    else $error("step pins still routed in serial mode");
  property p_write_in_serial;
    wr_w |-> serial_mode_out;
  endproperty
  a_write_in_serial: assert property (p_write_in_serial)
    else $error("register write outside serial mode");
  property p_one_target;
    wr_w |-> !(cfg_write_out && run_write_out);
  endproperty
  a_one_target: assert property (p_one_target)
    else $error("both registers written by one word");
  property p_bad_discards;
    $rose(serial_write_fault_out) |-> !wr_w;
  endproperty
  a_bad_discards: assert property (p_bad_discards)
    else $error("faulty transfer was latched");
  property p_fault_clear;
    $fell(serial_write_fault_out) |-> (wr_w || $past(wr_w) || !chip_reset_n_in || !$past(chip_reset_n_in, 3))
      or ##1 wr_w;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("write fault cleared without cause");
  property p_stall_en;
    stall_detect_en_out == (stall_threshold_out != 5'h00);
  endproperty
  a_stall_en: assert property (p_stall_en)
    else $error("stall enable disagrees with threshold");
  property p_angle_moves;
    $changed(step_angle_out) |-> (run_write_out || $past(run_write_out)) or ##1 run_write_out;
  endproperty
  a_angle_moves: assert property (p_angle_moves)
    else $error("step angle moved without run write");
endmodule // sscp_top_assertions

bind sscp_top sscp_top_assertions sscp_top_assertions_i (.clk_sys_in, .rst_n_in, .chip_reset_n_in,
  .fault_supply_in, .fault_open_load_in, .fault_temp_in, .fault_stall_in, .fault_short_in,
  .fault_indicator_out, .serial_mode_out, .step_pulse_out, .step_dir_out, .stall_threshold_out,
  .stall_detect_en_out, .step_angle_out, .cfg_write_out, .run_write_out, .serial_write_fault_out);

// *** tb/sscp_host_model.sv ***
// Host controller model driving the step, direction and resolution pins
`timescale 1ns/100ps
module sscp_host_model (
  // Clock
  input  wire clk_in,
  // Pins towards the device
  output reg  strobe_n_out,
  output reg  data_out,
  output reg  sck_out
);
  initial
  begin
    strobe_n_out = 1'b1;
    data_out     = 1'b0;
    sck_out      = 1'b0;
  end
  task automatic wait_neg(input integer n);
    repeat (n) @(negedge clk_in);
  endtask
  // Entry phases 10, 01, 10 then direction high, each held past the hold count
  task automatic enter(input integer first, input integer last);
    integer i;
    begin
      strobe_n_out = 1'b1;
      for (i = first; i < last; i = i + 1)
      begin
        sck_out  = (i < 3) ? ~i[0] : 1'b1;
        data_out = (i < 3) ? i[0] : 1'b1;
        wait_neg(14);
      end
    end
  endtask
  // One frame, MSB first; the link clock only toggles inside the frame, 160 ns period
  task automatic send(input [15:0] w, input integer n);
    integer i;
    begin
      sck_out      = 1'b0;
      strobe_n_out = 1'b0;
      wait_neg(4);
      for (i = 0; i < n; i = i + 1)
      begin
        data_out = w[15 - (i % 16)];
        wait_neg(4);
        sck_out = 1'b1;
        wait_neg(4);
        sck_out = 1'b0;
      end
      wait_neg(4);
      strobe_n_out = 1'b1;
      data_out     = ~data_out; // Released data never shows the last bit
      wait_neg(4);
    end
  endtask
endmodule // sscp_host_model

// *** tb/stepper_serial_config_port_bench.sv ***
// Self-checking bench for the serial configuration port
`timescale 1ns/100ps
module stepper_serial_config_port_bench;
  reg         clk_sys_in, rst_n_in, chip_reset_n_in;
  reg  [4:0]  flt;
  integer     n_mismatch, checked, k;
  wire        strobe_n, data, sck;
  wire        fault_indicator_out, serial_mode_out, step_pulse_out, step_dir_out, stall_detect_en_out;
  wire        recirc_low_side_out, bridge_off_out, serial_write_fault_out, diode_recirc_out;
  wire [1:0]  step_size_out;
  wire [7:0]  oc_delay_ticks_out, blank_ticks_out, pwm_period_ticks_out;
  wire [5:0]  open_load_pct_out, step_increment_out, step_angle_out;
  wire [4:0]  stall_threshold_out;
  wire [2:0]  fault_route_select_out;
  // Short timings keep the run brief: hold 10, acknowledge 30, exit 5 cycles
  sscp_top #(.SEQ_HOLD_NS(200), .ACK_PULSE_NS(600), .EXIT_NS(100)) sscp_top_i (
    .clk_sys_in, .rst_n_in, .ce_in(1'b1), .motion_pulse_in(strobe_n), .rotation_sense_in(data),
    .resolution_select_in(sck), .chip_reset_n_in, .fault_supply_in(flt[0]), .fault_open_load_in(flt[1]),
    .fault_temp_in(flt[2]), .fault_stall_in(flt[3]), .fault_short_in(flt[4]), .fault_indicator_out,
    .serial_mode_out, .step_pulse_out, .step_dir_out, .step_size_out, .oc_delay_ticks_out,
    .open_load_pct_out, .stall_threshold_out, .stall_detect_en_out, .recirc_low_side_out, .blank_ticks_out,
    .pwm_period_ticks_out, .fault_route_select_out, .diode_recirc_out, .bridge_off_out, .step_increment_out,
    .step_angle_out, .cfg_write_out(), .run_write_out(), .serial_write_fault_out);
  sscp_host_model sscp_host_model_i (.clk_in(clk_sys_in), .strobe_n_out(strobe_n), .data_out(data),
    .sck_out(sck));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  task automatic w(input integer n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic send(input [15:0] v, input integer n);
    begin
      sscp_host_model_i.send(v, n);
      w(4);
    end
  endtask
  // Power-on defaults as decoded settings
  task automatic t_reset;
    begin
      chk(serial_mode_out, 1'b0);
      chk(pwm_period_ticks_out, 8'hb8);
      chk({oc_delay_ticks_out, blank_ticks_out}, 16'h080e);
      chk(open_load_pct_out, 6'h14);
      chk(step_size_out, 2'h1);
      chk(fault_indicator_out, 1'b1);
    end
  endtask
  // Aborted entry, then full entry with a fault arriving inside the acknowledge
  task automatic t_entry;
    begin
      sscp_host_model_i.enter(0, 2);
      sscp_host_model_i.strobe_n_out = 1'b0;
      w(4);
      sscp_host_model_i.enter(2, 4);
      w(4);
      chk(serial_mode_out, 1'b0);
      sscp_host_model_i.enter(0, 4);
      w(12);
      chk({serial_mode_out, fault_indicator_out}, 2'h2);
      flt = 5'h04;
      w(4);
      chk(fault_indicator_out, 1'b1);
      flt = 5'h00;
      w(24);
      chk(fault_indicator_out, 1'b1);
    end
  endtask
  // Bad frame lengths, configuration fields and every period code
  task automatic t_config;
    begin
      send(16'h58ff, 15);
      chk({serial_write_fault_out, pwm_period_ticks_out}, 9'h1b8);
      send(16'h58ff, 16);
      chk({serial_write_fault_out, recirc_low_side_out, open_load_pct_out}, 8'h5e);
      chk({stall_detect_en_out, stall_threshold_out}, 6'h23);
      for (k = 0; k < 4; k = k + 1)
      begin
        send({3'h2, k[0], 10'h000, k[1:0]} | {13'h0000, k[1], 2'h0}, 16);
        chk(pwm_period_ticks_out, 16'(32'h80a0b8f0 >> (k * 8) & 32'hff));
        chk(oc_delay_ticks_out, k[0] ? 8'h10 : 8'h08);
        chk(blank_ticks_out, k[1] ? 8'h06 : 8'h0e);
        chk(stall_detect_en_out, 1'b0);
      end
      send(16'h4001, 17);
      chk(serial_write_fault_out, 1'b1);
      chip_reset_n_in = 1'b0;
      w(4);
      chip_reset_n_in = 1'b1;
      w(3);
      chk(serial_write_fault_out, 1'b0);
    end
  endtask
  // Run words: routing, bridge off and signed step increments
  task automatic t_run;
    begin
      send(16'hcb05, 16);
      chk({fault_route_select_out, diode_recirc_out, bridge_off_out, step_angle_out}, 11'h2c5);
      flt = 5'h04;
      w(4);
      chk(fault_indicator_out, 1'b1);
      flt = 5'h06;
      w(4);
      chk(fault_indicator_out, 1'b0);
      flt = 5'h00;
      send(16'hd03e, 16);
      chk({fault_route_select_out, diode_recirc_out, bridge_off_out, step_angle_out}, 11'h403);
      chk(step_increment_out, 6'h3e);
      flt = 5'h08;
      w(4);
      chk(fault_indicator_out, 1'b0);
      flt = 5'h00;
      w(4);
    end
  endtask
  // Leaving serial mode after the exit time, pins back to step functions
  task automatic t_exit;
    begin
      send(16'h0031, 16);
      chk(serial_mode_out, 1'b1);
      w(8);
      chk({serial_mode_out, fault_indicator_out}, 2'h0);
      sscp_host_model_i.sck_out = 1'b1;
      w(4);
      chk({step_size_out, step_pulse_out}, 3'h7);
      sscp_host_model_i.sck_out = 1'b0;
      w(4);
      chk(step_size_out, 2'h1);
    end
  endtask
  task results;
    begin
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Watchdog well beyond the roughly 1650 cycles of the sequence
  initial
  begin
    #200000;
    n_mismatch = n_mismatch + 1;
    results;
  end
  initial
  begin
    n_mismatch      = 0;
    checked         = 0;
    rst_n_in        = 1'b0;
    chip_reset_n_in = 1'b1;
    flt             = 5'h00;
    w(6);
    rst_n_in = 1'b1;
    w(6);
    t_reset;
    t_entry;
    t_config;
    t_run;
    t_exit;
    results;
  end
endmodule // stepper_serial_config_port_bench
